// ===== logic/udbp_pin_cell.sv
// per-pin steering of drive, pull-up and read view
`timescale 1ns/100ps
`default_nettype none
module udbp_pin_cell (
    // operating mode
    input wire logic ext_mode,
    input wire logic single_mode,
    // register bits for this pin
    input wire logic dir_bit,
    input wire logic latch_bit,
    input wire logic pullup_bit,
    // bus controller and pad
    input wire logic ebus_wr,
    input wire logic ebus_bit,
    input wire logic pad_level,
    // results
    output logic next_oe,
    output logic next_out,
    output logic next_pu,
    output logic view_bit
);

    // ------------------------------------------------------------
    // pin function
    // ------------------------------------------------------------
    // bus lines drive only on controller write cycles
    wire logic ext_drive = ext_mode & ebus_wr;
    // general output only in single-chip mode
    wire logic port_drive = single_mode & dir_bit;

    assign next_oe = ext_drive | port_drive;
    assign next_out = ext_drive ? ebus_bit : (port_drive & latch_bit);
    // pull-up only for a single-chip input pin
    assign next_pu = single_mode & ~dir_bit & pullup_bit;
    // output pins read back the latch, input pins the pad
    assign view_bit = dir_bit ? latch_bit : pad_level;

endmodule
`default_nettype wire

// ===== logic/udbp_port.sv
// upper data byte i/o port with direction, latch, view and pull-up
`timescale 1ns/100ps
`default_nettype none

// Operation
// - An eight-bit write-only direction register clears to zero on reset.
// - In modes 4 to 6 every pin is a two-way bus line, direction ignored.
// - In bus modes port bit n is data bus bit n plus 8, bits 15 down to 8.
// - In mode 7 a pin drives when its direction bit is 1, else is input.
// - A readable output latch resets to zero and feeds general outputs.
// - The level view returns latch bits for outputs and pads for inputs.
// - The level view is read-only and has no reset value of its own.
// - A readable pull-up register resets to zero; 1 asks for a pull-up.
// - Pull-ups work only in mode 7 and are set per pin.
// - In mode 7 a pull-up is on exactly for direction 0 and enable 1.
// - Pull-ups stay off on bus lines and outputs, and through reset.
module udbp_port (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // chip mode pins
    input wire logic [udbp_pkg::MODE_W-1:0] mode,
    // register port
    input wire udbp_pkg::udbp_req_t req,
    output logic [udbp_pkg::PORT_W-1:0] rdata,
    // external bus controller
    input wire udbp_pkg::udbp_ebus_t ebus,
    output logic [udbp_pkg::DBUS_W-1:0] ebus_din,
    // pads
    input wire logic [udbp_pkg::PORT_W-1:0] pin_in,
    output logic [udbp_pkg::PORT_W-1:0] pin_out,
    output logic [udbp_pkg::PORT_W-1:0] pin_oe,
    output logic [udbp_pkg::PORT_W-1:0] pin_pu
);
    import udbp_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [PORT_W-1:0] pin_direction;
    logic [PORT_W-1:0] output_latch;
    logic [PORT_W-1:0] pullup_enable;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // modes below 4 leave every pin an input with no pull-up
    wire logic ext_mode = (mode >= MODE_EXT_FIRST) &&
        (mode <= MODE_EXT_LAST);
    wire logic single_mode = (mode == MODE_SINGLE);

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    wire logic hit_dir = (req.addr == OFS_DIRECTION);
    wire logic hit_latch = (req.addr == OFS_LATCH);
    wire logic hit_view = (req.addr == OFS_LEVEL_VIEW);
    wire logic hit_pullup = (req.addr == OFS_PULLUP);
    wire logic wr_dir = req.wr & hit_dir;
    wire logic wr_latch = req.wr & hit_latch;
    wire logic wr_pullup = req.wr & hit_pullup;

    // ------------------------------------------------------------
    // per-pin steering
    // ------------------------------------------------------------
    logic [PORT_W-1:0] next_oe;
    logic [PORT_W-1:0] next_out;
    logic [PORT_W-1:0] next_pu;
    logic [PORT_W-1:0] view;
    // bus byte carried by the port
    wire logic [PORT_W-1:0] ebus_byte = ebus.dout[DBUS_LSB +: PORT_W];

    generate
        for (genvar i = 0; i < PORT_W; i++) begin : g_pin
            udbp_pin_cell u_cell (
                .ext_mode(ext_mode),
                .single_mode(single_mode),
                .dir_bit(pin_direction[i]),
                .latch_bit(output_latch[i]),
                .pullup_bit(pullup_enable[i]),
                .ebus_wr(ebus.wr),
                .ebus_bit(ebus_byte[i]),
                .pad_level(pin_in[i]),
                .next_oe(next_oe[i]),
                .next_out(next_out[i]),
                .next_pu(next_pu[i]),
                .view_bit(view[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // read data select
    // ------------------------------------------------------------
    // view is built live from latch and pads by direction, so it needs no reset value
    wire logic [PORT_W-1:0] read_sel =
        hit_view ? view :
        hit_latch ? output_latch :
        hit_pullup ? pullup_enable :
        RD_WRITE_ONLY;
    wire logic [PORT_W-1:0] next_rdata = req.rd ? read_sel : RD_IDLE;

    // external bus read byte lands on the upper data lines
    wire logic ebus_capture = ext_mode & ebus.rd;
    wire logic [DBUS_W-1:0] next_ebus_din =
        {pin_in, DBUS_IDLE[DBUS_LSB-1:0]};

    // ------------------------------------------------------------
    // registers written by software
    // ------------------------------------------------------------
    // direction register, write-only
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_direction <= RST_DIRECTION;
        end else if (wr_dir) begin
            pin_direction <= req.wdata;
        end
    end

    // output latch
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            output_latch <= RST_LATCH;
        end else if (wr_latch) begin
            output_latch <= req.wdata;
        end
    end

    // pull-up enable
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pullup_enable <= RST_PULLUP;
        end else if (wr_pullup) begin
            pullup_enable <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata <= RD_IDLE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // pad drive and pull-ups
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_oe <= '0;
            pin_out <= '0;
            pin_pu <= '0;
        end else begin
            pin_oe <= next_oe;
            pin_out <= next_out;
            pin_pu <= next_pu;
        end
    end

    // ------------------------------------------------------------
    // bus controller read path
    // ------------------------------------------------------------
    // holds the last captured byte between read cycles
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ebus_din <= DBUS_IDLE;
        end else if (ebus_capture) begin
            ebus_din <= next_ebus_din;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // direction clears through reset
    AST_DIR_RESET: assert property (
        @(posedge ref_clk) !nrst |=> pin_direction == RST_DIRECTION
    ) else $error("direction not cleared by reset");

    // direction never reads back
    AST_DIR_WO: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        req.rd && hit_dir |=> rdata == RD_WRITE_ONLY
    ) else $error("direction register read back");

    // bus modes drive exactly on controller writes
    AST_EXT_OE: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        ext_mode |=> pin_oe == {PORT_W{$past(ebus.wr)}}
    ) else $error("bus mode drive not following write cycles");

    // port pins carry data bus bits 15 to 8
    AST_EXT_MAP: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        ext_mode && ebus.wr |=>
            pin_out == $past(ebus.dout[DBUS_W-1:DBUS_LSB])
    ) else $error("bus byte not on port pins");

    // single-chip drive follows direction and latch
    AST_SINGLE_DRIVE: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        single_mode |=> pin_oe == $past(pin_direction) &&
            pin_out == ($past(pin_direction) & $past(output_latch))
    ) else $error("single-chip drive wrong");

    // latch write appears at the pin two edges later
    AST_LATCH_PIN: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        wr_latch && single_mode ##1 single_mode && !wr_dir |=>
            (pin_out & pin_direction) == ($past(req.wdata, 2) & pin_direction)
    ) else $error("latch write not driven");

    // view mixes latch and pad by direction
    AST_VIEW_READ: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        req.rd && hit_view |=> rdata ==
            (($past(pin_direction) & $past(output_latch)) |
             (~$past(pin_direction) & $past(pin_in)))
    ) else $error("level view wrong");

    // view ignores writes
    AST_VIEW_RO: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        req.wr && hit_view |=> $stable(pin_direction) &&
            $stable(output_latch) && $stable(pullup_enable)
    ) else $error("write to level view changed state");

    // pull-up register reads back what was written
    AST_PU_RW: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        wr_pullup ##1 req.rd && hit_pullup && !req.wr |=>
            rdata == $past(req.wdata, 2)
    ) else $error("pull-up register readback wrong");

    // no pull-up outside single-chip mode
    AST_PU_MODE: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !single_mode |=> pin_pu == '0
    ) else $error("pull-up on outside single-chip mode");

    // single-chip pull-up exactly for input with enable
    AST_PU_ON: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        single_mode |=>
            pin_pu == (~$past(pin_direction) & $past(pullup_enable))
    ) else $error("pull-up state wrong");

    // never a pull-up on a driven pin
    AST_PU_OFF: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (pin_oe & pin_pu) == '0
    ) else $error("pull-up on a driven pin");

    // pull-ups off through reset
    AST_PU_RST: assert property (
        @(posedge ref_clk) !nrst |=> pin_pu == '0
    ) else $error("pull-up on after reset");

    // latch and pull-up register clear through reset
    AST_LATCH_RESET: assert property (
        @(posedge ref_clk) !nrst |=>
            output_latch == RST_LATCH && pullup_enable == RST_PULLUP
    ) else $error("latch or pull-up register not cleared by reset");

    // modes below 4 neither drive nor pull up
    AST_IDLE_MODE: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !ext_mode && !single_mode |=> pin_oe == '0 && pin_pu == '0
    ) else $error("pin active outside the known modes");

    // bus read captures pad levels on the upper byte
    AST_EXT_READ: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        ebus_capture |=> ebus_din[DBUS_W-1:DBUS_LSB] == $past(pin_in) &&
            ebus_din[DBUS_LSB-1:0] == DBUS_IDLE[DBUS_LSB-1:0]
    ) else $error("bus read byte wrong");

    // read data stand only in the cycle after the strobe
    AST_RD_IDLE: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !req.rd |=> rdata == RD_IDLE
    ) else $error("read data outside answer cycle");

endmodule
`default_nettype wire

// ===== shared/udbp_pkg.sv
// constants and carrier types of the upper data byte i/o port
`default_nettype none
package udbp_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int ADDR_W = 2;
    localparam int DBUS_W = 16;
    localparam int MODE_W = 3;
    // port bit n sits on data bus bit n + DBUS_LSB
    localparam int DBUS_LSB = 8;

    // ------------------------------------------------------------
    // register offsets on the plain register port
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_LATCH = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_LEVEL_VIEW = 2'h2;
    localparam logic [ADDR_W-1:0] OFS_PULLUP = 2'h3;

    // ------------------------------------------------------------
    // reset values and fixed read values
    // ------------------------------------------------------------
    localparam logic [PORT_W-1:0] RST_DIRECTION = 8'h00;
    localparam logic [PORT_W-1:0] RST_LATCH = 8'h00;
    localparam logic [PORT_W-1:0] RST_PULLUP = 8'h00;
    localparam logic [PORT_W-1:0] RD_WRITE_ONLY = 8'h00;
    localparam logic [PORT_W-1:0] RD_IDLE = 8'h00;
    localparam logic [DBUS_W-1:0] DBUS_IDLE = 16'h0000;

    // ------------------------------------------------------------
    // operating modes from the chip mode pins
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_EXT_FIRST = 3'h4;
    localparam logic [MODE_W-1:0] MODE_EXT_LAST = 3'h6;
    localparam logic [MODE_W-1:0] MODE_SINGLE = 3'h7;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [PORT_W-1:0] wdata;
        logic wr;
        logic rd;
    } udbp_req_t;

    // external bus controller cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [DBUS_W-1:0] dout;
    } udbp_ebus_t;

endpackage
`default_nettype wire

// ===== testbench/udbp_far_model.sv
// far-side model: board pads and external bus controller
`timescale 1ns/100ps
`default_nettype none
module udbp_far_model (
    // clock
    input wire logic ref_clk,
    // port pads
    input wire logic [udbp_pkg::PORT_W-1:0] pin_out,
    input wire logic [udbp_pkg::PORT_W-1:0] pin_oe,
    input wire logic [udbp_pkg::PORT_W-1:0] pin_pu,
    output logic [udbp_pkg::PORT_W-1:0] pin_in,
    // board drivers set by the bench
    input wire logic [udbp_pkg::PORT_W-1:0] brd_en,
    input wire logic [udbp_pkg::PORT_W-1:0] brd_val,
    // bus controller cycles
    output var udbp_pkg::udbp_ebus_t ebus
);
    import udbp_pkg::*;

    logic [PORT_W-1:0] flt = 8'h55;

    // ------------------------------------------------------------
    // pad resolution
    // ------------------------------------------------------------
    // a floating pad shows a pattern that flips every cycle
    always_ff @(posedge ref_clk) begin
        flt <= ~flt;
    end

    // port drive wins, then the board, then the pull-up, else noise
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & brd_en & brd_val) |
        (~pin_oe & ~brd_en & pin_pu) | (~pin_oe & ~brd_en & ~pin_pu & flt);

    // ------------------------------------------------------------
    // bus controller cycles, each taken at the next rising edge
    // ------------------------------------------------------------
    initial begin
        ebus = '{wr: 1'b0, rd: 1'b0, dout: DBUS_IDLE};
    end

    // write cycle puts data on bits 15:0
    task automatic bus_wr(input logic [DBUS_W-1:0] d);
        ebus <= '{wr: 1'b1, rd: 1'b0, dout: d};
        @(posedge ref_clk);
        #1;
    endtask

    // read cycle, released data lines show inverted noise
    task automatic bus_rd();
        ebus <= '{wr: 1'b0, rd: 1'b1, dout: ~ebus.dout};
        @(posedge ref_clk);
        #1;
    endtask

    // no cycle
    task automatic bus_idle();
        ebus <= '{wr: 1'b0, rd: 1'b0, dout: ~ebus.dout};
        @(posedge ref_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ===== testbench/udbp_port_tb.sv
// self-checking bench for the upper data byte i/o port
`timescale 1ns/100ps
`default_nettype none
module udbp_port_tb;
    import udbp_pkg::*;

    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [MODE_W-1:0] mode = MODE_SINGLE;
    udbp_req_t req = '0;
    logic [PORT_W-1:0] rdata;
    udbp_ebus_t ebus;
    logic [DBUS_W-1:0] ebus_din;
    logic [PORT_W-1:0] pin_in;
    logic [PORT_W-1:0] pin_out;
    logic [PORT_W-1:0] pin_oe;
    logic [PORT_W-1:0] pin_pu;
    logic [PORT_W-1:0] brd_en = 8'h00;
    logic [PORT_W-1:0] brd_val = 8'h00;
    logic [PORT_W-1:0] v;
    logic [DBUS_W-1:0] exp_din;
    int error_cnt = 0;
    int tests_run = 0;

    // ------------------------------------------------------------
    // clock, design and far side
    // ------------------------------------------------------------
    always #25 ref_clk = ~ref_clk;

    udbp_port udbp_port_inst (.ref_clk(ref_clk), .nrst(nrst), .mode(mode),
        .req(req), .rdata(rdata), .ebus(ebus), .ebus_din(ebus_din),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu));

    udbp_far_model udbp_far_model_inst (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pu(pin_pu), .pin_in(pin_in), .brd_en(brd_en),
        .brd_val(brd_val), .ebus(ebus));

    // ------------------------------------------------------------
    // compare and register port tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] seen, input logic [7:0] exp);
        chk({8'h00, seen}, {8'h00, exp});
    endtask

    // one-cycle write strobe, replaced by whatever comes next
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        logic [7:0] d;
        reg_rd(a, d);
        chk8(d, e);
    endtask

    task automatic idle(input int n);
        req <= '{addr: 2'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        #1;
        nrst <= 1'b1;
        idle(1);
        // reset values and write-only direction
        rd_chk(OFS_DIRECTION, 8'h00);
        rd_chk(OFS_LATCH, 8'h00);
        rd_chk(OFS_PULLUP, 8'h00);
        chk8(pin_oe, 8'h00);
        chk8(pin_pu, 8'h00);
        $display("test reset values done");
        // single-chip mode: drive, pull-up and level view
        brd_en <= 8'h0f;
        brd_val <= 8'h5a;
        reg_wr(OFS_DIRECTION, 8'hf0);
        reg_wr(OFS_LATCH, 8'ha5);
        reg_wr(OFS_PULLUP, 8'h3c);
        idle(1);
        chk8(pin_oe, 8'hf0);
        chk8(pin_out & 8'hf0, 8'ha0);
        chk8(pin_pu, 8'h0c);
        rd_chk(OFS_LEVEL_VIEW, 8'haa);
        reg_wr(OFS_LEVEL_VIEW, 8'hff);
        rd_chk(OFS_LATCH, 8'ha5);
        rd_chk(OFS_LEVEL_VIEW, 8'haa);
        rd_chk(OFS_PULLUP, 8'h3c);
        rd_chk(OFS_DIRECTION, 8'h00);
        brd_en <= 8'h00;
        reg_rd(OFS_LEVEL_VIEW, v);
        chk8(v & 8'hfc, 8'hac);
        // per-pin pull-up control, direction written whole
        reg_wr(OFS_PULLUP, 8'hff);
        rd_chk(OFS_PULLUP, 8'hff);
        reg_wr(OFS_DIRECTION, 8'h00);
        idle(1);
        chk8(pin_pu, 8'hff);
        reg_wr(OFS_DIRECTION, 8'h81);
        idle(1);
        chk8(pin_pu, 8'h7e);
        $display("test single-chip mode done");
        // bus modes 4 to 6, then mode 7 where the bus is ignored
        exp_din = 16'h0000;
        for (int m = 4; m <= 7; m++) begin
            mode <= MODE_W'(m);
            brd_en <= 8'hff;
            brd_val <= 8'h96 ^ 8'(m);
            idle(2);
            udbp_far_model_inst.bus_wr({8'h3c ^ 8'(m), 8'h77});
            if (m < 7) begin
                chk8(pin_oe, 8'hff);
                chk8(pin_out, 8'h3c ^ 8'(m));
                chk8(pin_pu, 8'h00);
                exp_din = {8'h96 ^ 8'(m), 8'h00};
            end else begin
                chk8(pin_oe, 8'h81);
                chk8(pin_pu, 8'h7e);
            end
            udbp_far_model_inst.bus_idle();
            chk8(pin_oe, (m < 7) ? 8'h00 : 8'h81);
            udbp_far_model_inst.bus_rd();
            chk(ebus_din, exp_din);
            udbp_far_model_inst.bus_idle();
        end
        $display("test bus modes done");
        // mode 3: no drive and no pull-up whatever the registers say
        mode <= 3'h3;
        idle(2);
        chk8(pin_oe, 8'h00);
        chk8(pin_pu, 8'h00);
        $display("test unused modes done");
        // reset in mid-run clears registers and pull-ups
        mode <= MODE_SINGLE;
        nrst <= 1'b0;
        idle(2);
        nrst <= 1'b1;
        idle(1);
        chk8(pin_pu, 8'h00);
        chk8(pin_oe, 8'h00);
        chk(ebus_din, 16'h0000);
        rd_chk(OFS_LATCH, 8'h00);
        rd_chk(OFS_PULLUP, 8'h00);
        idle(1);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
`default_nettype wire
